//--- design/conv_sequencer.v
// Purpose: Conversion sequencer: power-up start, single and continuous modes.
// Assumes: Start, halt and trigger are one-cycle pulses.
// Notes: Each conversion lasts the longest time for the chosen resolution.
`timescale 1ns/100ps
`default_nettype none
module conv_sequencer #(
    parameter CNT_W = 23,
    parameter [31:0] T10 = 32'd625000,
    parameter [31:0] T11 = 32'd1250000,
    parameter [31:0] T12 = 32'd2500000,
    parameter [31:0] T13 = 32'd5000000
) (
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Controls.
    input wire start_cmd,
    input wire halt_cmd,
    input wire trigger,
    input wire single_mode,
    input wire auto_convert_at_powerup,
    input wire [1:0] res,
    // Status.
    output wire busy,
    output wire done_pulse
);
    localparam ST_PWR = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_CONV = 2'h2;
    reg [1:0] state_ff, nxt_state;
    reg cont_ff, nxt_cont;
    reg [CNT_W-1:0] cnt_ff, nxt_cnt;
    reg [CNT_W-1:0] lim;
    reg fin;

    always @* begin
        case (res)
            2'h0: lim = T10[CNT_W-1:0] - 1'b1;
            2'h1: lim = T11[CNT_W-1:0] - 1'b1;
            2'h2: lim = T12[CNT_W-1:0] - 1'b1;
            default: lim = T13[CNT_W-1:0] - 1'b1;
        endcase
    end

    // Busy before the first edge too, so the power-up start is never seen as done.
    assign busy = (state_ff == ST_CONV) | ((state_ff == ST_PWR) & auto_convert_at_powerup);
    assign done_pulse = fin;

    always @* begin
        nxt_state = state_ff;
        nxt_cont = cont_ff;
        nxt_cnt = cnt_ff;
        fin = 1'b0;
        case (state_ff)
            ST_PWR: begin
                nxt_state = auto_convert_at_powerup ? ST_CONV : ST_IDLE;
                nxt_cont = auto_convert_at_powerup & ~single_mode;
                nxt_cnt = lim;
            end
            ST_IDLE: begin
                if (start_cmd | trigger) begin
                    nxt_state = ST_CONV;
                    nxt_cont = ~single_mode;
                    nxt_cnt = lim;
                end
            end
            ST_CONV: begin
                // The mode bit is latched at start; changing it later does not stop repeats.
                if (halt_cmd) begin
                    nxt_cont = 1'b0;
                end
                if (cnt_ff == {CNT_W{1'b0}}) begin
                    fin = 1'b1;
                    nxt_cnt = lim;
                    if (!cont_ff || halt_cmd) begin
                        nxt_state = ST_IDLE;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (!resetn) begin
            state_ff <= ST_PWR;
            cont_ff <= 1'b0;
            cnt_ff <= {CNT_W{1'b0}};
        end else begin
            state_ff <= nxt_state;
            cont_ff <= nxt_cont;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

//--- design/thermo_cfg_defs.vh
// Purpose: Shared constants for the thermostat configuration register block.
// Assumes: AXI4-Lite register access, 25 MHz clock.
// Notes: Register indices are multiplied by four to form byte addresses.
`ifndef THERMO_CFG_DEFS_VH
`define THERMO_CFG_DEFS_VH

// Register indices; the byte address is four times the index.
`define IDX_CFG_MSB 12'h0ac
`define IDX_CFG_LSB 12'h0ad
`define IDX_HI_THRESH 12'h000
`define IDX_LO_THRESH 12'h001
`define IDX_COMMAND 12'h002

// Field positions within the 16-bit configuration word.
`define BIT_DONE 15
`define BIT_NVB 14
`define BIT_THF 13
`define BIT_TLF 12
`define BIT_RES_HI 11
`define BIT_RES_LO 10
`define BIT_AUTO_CONVERT_AT_POWERUP 9
`define BIT_SINGLE 8
`define BIT_FORCE 7
`define BIT_SENSE 6
`define BIT_STRAP2 5
`define BIT_STRAP1 4
`define BIT_STRAP0 3

// Command register bits.
`define CMD_BEGIN 0
`define CMD_HALT 1
`define CMD_NV_STORE 2

// Factory and power-up values.
`define RST_RES 2'h3
`define RST_AUTO_CONVERT_AT_POWERUP 1'h0
`define RST_SINGLE 1'h0
`define RST_FORCE 1'h1
`define RST_SENSE 1'h0
`define RST_SCRATCH 3'h0
`define RST_THRESH 16'h0000

// Timing: longest conversion times in ms, and the clock rate in kHz.
`define CONV_MS_10 25
`define CONV_MS_11 50
`define CONV_MS_12 100
`define CONV_MS_13 200
`define CLK_KHZ 25000
`define NV_WRITE_CYCLES 16'h03e8

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- design/thermo_config_status_register.v
// Purpose: Thermostat configuration and status register with AXI4-Lite access.
// Assumes: Strap pins and temperature input are synchronous to CLK.
// Notes: RESETN stands in for power-up; nonvolatile fields take their factory values.
`timescale 1ns/100ps
`default_nettype none
`include "thermo_cfg_defs.vh"
module thermo_config_status_register #(
    parameter CNT_W = 23,
    parameter [31:0] CONV_CYC_10 = `CONV_MS_10 * `CLK_KHZ,
    parameter [31:0] CONV_CYC_11 = `CONV_MS_11 * `CLK_KHZ,
    parameter [31:0] CONV_CYC_12 = `CONV_MS_12 * `CLK_KHZ,
    parameter [31:0] CONV_CYC_13 = `CONV_MS_13 * `CLK_KHZ,
    parameter [15:0] NV_CYC = `NV_WRITE_CYCLES
) (
    // Clock and reset.
    input wire CLK,
    input wire RESETN,
    // AXI4-Lite write address.
    input wire [31:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    // AXI4-Lite write data.
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    // AXI4-Lite write response.
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // AXI4-Lite read address.
    input wire [31:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    // AXI4-Lite read data.
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // Address strap pins.
    input wire ADDR_STRAP_2,
    input wire ADDR_STRAP_1,
    input wire ADDR_STRAP_0,
    // Temperature from the conversion engine, valid when a conversion ends.
    input wire [15:0] TEMP_VALUE,
    // Programmable output pin, open drain.
    output reg PROGRAMMABLE_OUTPUT_PIN_OUT,
    output wire PROGRAMMABLE_OUTPUT_PIN_OE_N
);
    // Decoded register selects.
    localparam SEL_NONE = 3'h0;
    localparam SEL_MSB = 3'h1;
    localparam SEL_LSB = 3'h2;
    localparam SEL_HI = 3'h3;
    localparam SEL_LO = 3'h4;
    localparam SEL_CMD = 3'h5;

    // Maps a byte address to a register select; unaligned addresses are unmapped.
    function [2:0] decode;
        input [31:0] addr;
        begin
            if (addr[1:0] != 2'h0 || addr[31:14] != 18'h00000) begin
                decode = SEL_NONE;
            end else if (addr[13:2] == `IDX_CFG_MSB) begin
                decode = SEL_MSB;
            end else if (addr[13:2] == `IDX_CFG_LSB) begin
                decode = SEL_LSB;
            end else if (addr[13:2] == `IDX_HI_THRESH) begin
                decode = SEL_HI;
            end else if (addr[13:2] == `IDX_LO_THRESH) begin
                decode = SEL_LO;
            end else if (addr[13:2] == `IDX_COMMAND) begin
                decode = SEL_CMD;
            end else begin
                decode = SEL_NONE;
            end
        end
    endfunction

    // Stored configuration fields.
    reg [1:0] res_ff;
    reg auto_convert_at_powerup_ff;
    reg single_ff;
    reg force_ff;
    reg sense_ff;
    reg [2:0] scratch_ff;
    reg thf_ff;
    reg tlf_ff;
    reg [15:0] hi_thresh_ff;
    reg [15:0] lo_thresh_ff;
    reg [15:0] nv_cnt_ff;
    reg strap1_prev_ff;

    // Write channel capture; address and data may arrive in either order.
    reg aw_held_ff;
    reg w_held_ff;
    reg [31:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;

    wire conv_busy;
    wire conv_done;
    wire hit_hi;
    wire hit_lo;
    wire nv_busy;
    wire [15:0] cfg_word;
    wire [2:0] wsel;
    wire [2:0] rsel;
    wire do_write;
    wire wr_b0;
    wire wr_b1;
    wire begin_cmd;
    wire halt_cmd;
    wire nv_store_cmd;
    wire strap_trigger;
    wire clr_thf;
    wire clr_tlf;

    assign do_write = aw_held_ff & w_held_ff & ~S_AXI_BVALID;
    assign wsel = decode(aw_addr_ff);
    assign rsel = decode(S_AXI_ARADDR);
    assign wr_b0 = do_write & w_strb_ff[0];
    assign wr_b1 = do_write & w_strb_ff[1];

    // Commands are self-clearing strobes and read back as zero.
    assign begin_cmd = wr_b0 & (wsel == SEL_CMD) & w_data_ff[`CMD_BEGIN];
    assign halt_cmd = wr_b0 & (wsel == SEL_CMD) & w_data_ff[`CMD_HALT];
    assign nv_store_cmd = wr_b0 & (wsel == SEL_CMD) & w_data_ff[`CMD_NV_STORE];

    // Only a low-to-high transition triggers, so a pin held high starts nothing more.
    assign strap_trigger = single_ff & auto_convert_at_powerup_ff & ADDR_STRAP_1 & ~strap1_prev_ff;

    assign nv_busy = (nv_cnt_ff != 16'h0000);

    // Writing 0 clears a flag; writing 1 leaves it alone.
    assign clr_thf = wr_b0 & (wsel == SEL_MSB) & ~w_data_ff[`BIT_THF - 8];
    assign clr_tlf = wr_b0 & (wsel == SEL_MSB) & ~w_data_ff[`BIT_TLF - 8];

    assign cfg_word = {
        ~conv_busy,
        nv_busy,
        thf_ff,
        tlf_ff,
        res_ff,
        auto_convert_at_powerup_ff,
        single_ff,
        force_ff,
        sense_ff,
        ADDR_STRAP_2,
        ADDR_STRAP_1,
        ADDR_STRAP_0,
        scratch_ff
    };

    conv_sequencer #(
        .CNT_W(CNT_W),
        .T10(CONV_CYC_10),
        .T11(CONV_CYC_11),
        .T12(CONV_CYC_12),
        .T13(CONV_CYC_13)
    ) u_seq (
        .clk(CLK),
        .resetn(RESETN),
        .start_cmd(begin_cmd),
        .halt_cmd(halt_cmd),
        .trigger(strap_trigger),
        .single_mode(single_ff),
        .auto_convert_at_powerup(auto_convert_at_powerup_ff),
        .res(res_ff),
        .busy(conv_busy),
        .done_pulse(conv_done)
    );

    thermostat_out u_tstat (
        .clk(CLK),
        .resetn(RESETN),
        .sample(conv_done),
        .temp(TEMP_VALUE),
        .hi_thresh(hi_thresh_ff),
        .lo_thresh(lo_thresh_ff),
        .force_sel(force_ff),
        .sense_sel(sense_ff),
        .hit_hi(hit_hi),
        .hit_lo(hit_lo),
        .po_oe_n_ff(PROGRAMMABLE_OUTPUT_PIN_OE_N)
    );

    // Write address and data channels.
    always @(posedge CLK) begin
        if (!RESETN) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 32'h00000000;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            if (S_AXI_AWVALID && !S_AXI_AWREADY && !aw_held_ff) begin
                S_AXI_AWREADY <= 1'b1;
                aw_held_ff <= 1'b1;
                aw_addr_ff <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !S_AXI_WREADY && !w_held_ff) begin
                S_AXI_WREADY <= 1'b1;
                w_held_ff <= 1'b1;
                w_data_ff <= S_AXI_WDATA;
                w_strb_ff <= S_AXI_WSTRB;
            end
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
        end
    end

    // Read channel: data is valid in the same cycle that the address is accepted.
    always @(posedge CLK) begin
        if (!RESETN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= 1'b0;
            if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID) begin
                S_AXI_ARREADY <= 1'b1;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= `RESP_OKAY;
                case (rsel)
                    SEL_MSB: S_AXI_RDATA <= {24'h000000, cfg_word[15:8]};
                    SEL_LSB: S_AXI_RDATA <= {24'h000000, cfg_word[7:0]};
                    SEL_HI: S_AXI_RDATA <= {16'h0000, hi_thresh_ff};
                    SEL_LO: S_AXI_RDATA <= {16'h0000, lo_thresh_ff};
                    SEL_CMD: S_AXI_RDATA <= 32'h00000000;
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                        S_AXI_RRESP <= `RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Configuration fields. DONE, NVB and strap bits have no storage, so writes to them vanish.
    always @(posedge CLK) begin
        if (!RESETN) begin
            res_ff <= `RST_RES;
            auto_convert_at_powerup_ff <= `RST_AUTO_CONVERT_AT_POWERUP;
            single_ff <= `RST_SINGLE;
            force_ff <= `RST_FORCE;
            sense_ff <= `RST_SENSE;
            scratch_ff <= `RST_SCRATCH;
            hi_thresh_ff <= `RST_THRESH;
            lo_thresh_ff <= `RST_THRESH;
        end else begin
            if (wr_b0 && wsel == SEL_MSB) begin
                res_ff <= w_data_ff[`BIT_RES_HI - 8:`BIT_RES_LO - 8];
                auto_convert_at_powerup_ff <= w_data_ff[`BIT_AUTO_CONVERT_AT_POWERUP - 8];
                single_ff <= w_data_ff[`BIT_SINGLE - 8];
            end
            if (wr_b0 && wsel == SEL_LSB) begin
                force_ff <= w_data_ff[`BIT_FORCE];
                sense_ff <= w_data_ff[`BIT_SENSE];
                scratch_ff <= w_data_ff[2:0];
            end
            if (wr_b0 && wsel == SEL_HI) begin
                hi_thresh_ff[7:0] <= w_data_ff[7:0];
            end
            if (wr_b1 && wsel == SEL_HI) begin
                hi_thresh_ff[15:8] <= w_data_ff[15:8];
            end
            if (wr_b0 && wsel == SEL_LO) begin
                lo_thresh_ff[7:0] <= w_data_ff[7:0];
            end
            if (wr_b1 && wsel == SEL_LO) begin
                lo_thresh_ff[15:8] <= w_data_ff[15:8];
            end
        end
    end

    // Sticky flags: a hit in the same cycle as a clear keeps the flag set.
    always @(posedge CLK) begin
        if (!RESETN) begin
            thf_ff <= 1'b0;
            tlf_ff <= 1'b0;
        end else begin
            thf_ff <= hit_hi | (thf_ff & ~clr_thf);
            tlf_ff <= hit_lo | (tlf_ff & ~clr_tlf);
        end
    end

    // Nonvolatile store timer; a store request while busy is dropped.
    always @(posedge CLK) begin
        if (!RESETN) begin
            nv_cnt_ff <= 16'h0000;
        end else if (nv_store_cmd && !nv_busy) begin
            nv_cnt_ff <= NV_CYC;
        end else if (nv_busy) begin
            nv_cnt_ff <= nv_cnt_ff - 16'h0001;
        end
    end

    // Trigger edge history and the constant-low drive value of the pin.
    always @(posedge CLK) begin
        if (!RESETN) begin
            strap1_prev_ff <= 1'b1;
            PROGRAMMABLE_OUTPUT_PIN_OUT <= 1'b0;
        end else begin
            strap1_prev_ff <= ADDR_STRAP_1;
            PROGRAMMABLE_OUTPUT_PIN_OUT <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- design/thermostat_out.v
// Purpose: Threshold compare and open-drain output drive.
// Assumes: Temperatures are two's complement, compared on each completed conversion.
// Notes: Output enable is low while the pin is pulled low.
`timescale 1ns/100ps
`default_nettype none
module thermostat_out (
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Measurement.
    input wire sample,
    input wire [15:0] temp,
    input wire [15:0] hi_thresh,
    input wire [15:0] lo_thresh,
    // Output configuration.
    input wire force_sel,
    input wire sense_sel,
    // Results.
    output wire hit_hi,
    output wire hit_lo,
    output reg po_oe_n_ff
);
    reg alarm_ff;
    wire nxt_alarm;

    assign hit_hi = sample & ($signed(temp) >= $signed(hi_thresh));
    assign hit_lo = sample & ($signed(temp) <= $signed(lo_thresh));
    // Hysteresis: the alarm holds between the two thresholds.
    assign nxt_alarm = hit_hi ? 1'b1 : (hit_lo ? 1'b0 : alarm_ff);

    always @(posedge clk) begin
        if (!resetn) begin
            alarm_ff <= 1'b0;
            po_oe_n_ff <= 1'b1;
        end else begin
            alarm_ff <= nxt_alarm;
            if (!force_sel) begin
                po_oe_n_ff <= 1'b0;
            end else if (sense_sel) begin
                po_oe_n_ff <= nxt_alarm;
            end else begin
                po_oe_n_ff <= ~nxt_alarm;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/axi_lite_master.sv
// Purpose: Bus master standing in for the host.
// Assumes: One request at a time, started by go.
// Notes: Released lines show the inverse of their last value, so stale data cannot pass.
`timescale 1ns/100ps
`default_nettype none
module axi_lite_master (
    // Requests.
    input wire logic clk,
    input wire logic go,
    input wire logic wr,
    input wire logic [31:0] ad,
    input wire logic [31:0] wd,
    output logic fin = 1'b0,
    output logic [31:0] rdv = 32'h0,
    output logic [1:0] rsp = 2'h0,
    // Bus.
    output logic [31:0] awaddr = 32'h0,
    output logic awvalid = 1'b0,
    input wire logic awready,
    output logic [31:0] wdata = 32'h0,
    output logic [3:0] wstrb = 4'hf,
    output logic wvalid = 1'b0,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready = 1'b0,
    output logic [31:0] araddr = 32'h0,
    output logic arvalid = 1'b0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready = 1'b0
);
    always @(posedge clk) begin
        fin <= 1'b0;
        if (go && wr) begin
            {awvalid, wvalid} <= 2'h3;
            awaddr <= ad;
            wdata <= wd;
        end
        if (go && !wr) begin
            arvalid <= 1'b1;
            araddr <= ad;
        end
        if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~awaddr;
        end
        if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~wdata;
        end
        if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~araddr;
        end
        if (bvalid) begin
            {bready, fin} <= {~bready, bready};
            rsp <= bresp;
        end
        if (rvalid) begin
            {rready, fin} <= {~rready, rready};
            {rdv, rsp} <= {rdata, rresp};
        end
    end
endmodule
`default_nettype wire

//--- testbench/thermo_cfg_props.sv
// Purpose: Concurrent checks on the thermostat register's bus and pin.
// Assumes: The bench keeps one write and one read in flight at most.
// Notes: Attached to the top module by bind.
`timescale 1ns/100ps
`default_nettype none
module thermo_cfg_props (
    // Clock and reset.
    input wire CLK,
    input wire RESETN,
    // Bus handshakes.
    input wire S_AXI_AWREADY,
    input wire S_AXI_WREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // Output pin.
    input wire PROGRAMMABLE_OUTPUT_PIN_OUT,
    input wire PROGRAMMABLE_OUTPUT_PIN_OE_N
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    a_aw_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("awready held");
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_read_answer: assert property (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID |=> S_AXI_ARREADY && S_AXI_RVALID)
        else $error("read not answered");
    a_b_cause: assert property ($rose(S_AXI_BVALID) |-> $past(S_AXI_WREADY) && $past(S_AXI_AWREADY))
        else $error("response without write");
    a_resp_code: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0 || S_AXI_BRESP == 2'h2)
        else $error("bad write response");
    a_err_data: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
        else $error("error read carries data");
    a_pin_low: assert property (PROGRAMMABLE_OUTPUT_PIN_OUT == 1'b0)
        else $error("pin driven high");
    c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_err: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
    c_pull: cover property ($fell(PROGRAMMABLE_OUTPUT_PIN_OE_N));
endmodule
bind thermo_config_status_register thermo_cfg_props u_props (.CLK(CLK), .RESETN(RESETN),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .PROGRAMMABLE_OUTPUT_PIN_OUT(PROGRAMMABLE_OUTPUT_PIN_OUT),
    .PROGRAMMABLE_OUTPUT_PIN_OE_N(PROGRAMMABLE_OUTPUT_PIN_OE_N));
`default_nettype wire

//--- testbench/thermo_config_status_register_tb.sv
// Purpose: Self-checking bench for the thermostat configuration register.
// Assumes: Conversions shortened to 20, 40, 80 and 160 cycles.
// Notes: Polling reads are coarse, so bounds carry margin.
`timescale 1ns/100ps
`default_nettype none
`include "thermo_cfg_defs.vh"
module thermo_config_status_register_tb;
    localparam logic [31:0] A_MSB = `IDX_CFG_MSB * 4;
    localparam logic [31:0] A_LSB = `IDX_CFG_LSB * 4;
    localparam logic [31:0] A_CMD = `IDX_COMMAND * 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic [31:0] ad = 32'h0;
    logic [31:0] wd = 32'h0;
    logic [2:0] strap = 3'h5;
    logic [15:0] temp = 16'h0;
    wire fin, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    wire pin_out, oe_n;
    wire [31:0] rdv, awaddr, wdata, araddr, rdata;
    wire [1:0] rsp, bresp, rresp;
    wire [3:0] wstrb;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    axi_lite_master host (.clk(clk), .go(go), .wr(wr), .ad(ad), .wd(wd), .fin(fin), .rdv(rdv),
        .rsp(rsp), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    thermo_config_status_register #(.CONV_CYC_10(20), .CONV_CYC_11(40), .CONV_CYC_12(80),
        .CONV_CYC_13(160), .NV_CYC(16'd16)) dut (.CLK(clk), .RESETN(resetn),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .ADDR_STRAP_2(strap[2]), .ADDR_STRAP_1(strap[1]), .ADDR_STRAP_0(strap[0]),
        .TEMP_VALUE(temp), .PROGRAMMABLE_OUTPUT_PIN_OUT(pin_out),
        .PROGRAMMABLE_OUTPUT_PIN_OE_N(oe_n));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask
    // The master takes go an edge later and pulses fin for one cycle.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        go <= 1'b1;
        wr <= w;
        ad <= a;
        wd <= d;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 50 && fin !== 1'b1; i++)
            @(posedge clk);
        cmp_bit(fin, 1'b1);
    endtask
    task automatic wait_done(input logic want);
        int i;
        for (i = 0; i < 80; i++) begin
            bus(1'b0, A_MSB, 32'h0);
            if (rdv[7] === want)
                break;
        end
        cmp_bit(rdv[7], want);
    endtask
    task automatic t_fields;
        bus(1'b0, A_MSB, 32'h0);
        cmp_word(rdv, 32'h8c);
        bus(1'b0, A_LSB, 32'h0);
        cmp_word(rdv, 32'ha8);
        bus(1'b1, A_LSB, 32'hff);
        bus(1'b0, A_LSB, 32'h0);
        cmp_word(rdv, 32'hef);
        strap <= 3'h2;
        bus(1'b0, A_LSB, 32'h0);
        cmp_word(rdv, 32'hd7);
        bus(1'b1, A_MSB, 32'hc1);
        bus(1'b0, A_MSB, 32'h0);
        cmp_word(rdv, 32'h81);
        $display("fields test done");
    endtask
    task automatic t_single;
        temp <= 16'h0200;
        bus(1'b1, 32'h0, 32'h0100);
        bus(1'b1, 32'h4, 32'hff00);
        bus(1'b1, A_CMD, 32'h1);
        bus(1'b0, A_MSB, 32'h0);
        cmp_word(rdv, 32'h01);
        wait_done(1'b1);
        cmp_word(rdv, 32'ha1);
        repeat (40) @(posedge clk);
        bus(1'b0, A_MSB, 32'h0);
        cmp_word(rdv, 32'ha1);
        cmp_bit(oe_n, 1'b1);
        bus(1'b1, A_LSB, 32'h47);
        repeat (2) @(posedge clk);
        cmp_bit(oe_n, 1'b0);
        bus(1'b1, A_LSB, 32'h87);
        repeat (2) @(posedge clk);
        cmp_bit(oe_n, 1'b0);
        $display("single test done");
    endtask
    task automatic t_low;
        bus(1'b1, A_MSB, 32'h0d);
        bus(1'b0, A_MSB, 32'h0);
        cmp_word(rdv, 32'h8d);
        temp <= 16'hfe00;
        bus(1'b1, A_CMD, 32'h1);
        repeat (110) @(posedge clk);
        bus(1'b0, A_MSB, 32'h0);
        cmp_word(rdv, 32'h0d);
        wait_done(1'b1);
        cmp_word(rdv, 32'h9d);
        $display("low flag test done");
    endtask
    // A flag set again after clearing proves repeats.
    task automatic t_repeat;
        bus(1'b1, A_MSB, 32'h00);
        bus(1'b1, A_CMD, 32'h1);
        repeat (30) @(posedge clk);
        bus(1'b1, A_MSB, 32'h00);
        repeat (30) @(posedge clk);
        bus(1'b0, A_MSB, 32'h0);
        cmp_bit(rdv[4], 1'b1);
        bus(1'b1, A_MSB, 32'h01);
        repeat (30) @(posedge clk);
        bus(1'b0, A_MSB, 32'h0);
        cmp_bit(rdv[4], 1'b1);
        bus(1'b1, A_CMD, 32'h2);
        repeat (30) @(posedge clk);
        bus(1'b1, A_MSB, 32'h01);
        repeat (30) @(posedge clk);
        bus(1'b0, A_MSB, 32'h0);
        cmp_word(rdv, 32'h81);
        $display("repeat test done");
    endtask
    task automatic t_misc;
        bus(1'b1, A_CMD, 32'h4);
        bus(1'b0, A_MSB, 32'h0);
        cmp_bit(rdv[6], 1'b1);
        repeat (20) @(posedge clk);
        bus(1'b0, A_MSB, 32'h0);
        cmp_bit(rdv[6], 1'b0);
        strap <= 3'h0;
        bus(1'b1, A_MSB, 32'h03);
        repeat (4) @(posedge clk);
        strap <= 3'h2;
        bus(1'b0, A_MSB, 32'h0);
        cmp_bit(rdv[7], 1'b0);
        wait_done(1'b1);
        repeat (40) @(posedge clk);
        bus(1'b0, A_MSB, 32'h0);
        cmp_bit(rdv[7], 1'b1);
        bus(1'b0, 32'h100, 32'h0);
        cmp_word({rdv[31:2], rsp}, 32'h2);
        bus(1'b1, 32'h100, 32'h0);
        cmp_word({30'h0, rsp}, 32'h2);
        $display("misc test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        cmp_bit(oe_n, 1'b1);
        t_fields();
        t_single();
        t_low();
        t_repeat();
        t_misc();
        test_done();
    end
endmodule
`default_nettype wire
